// >>> pst_defines.vh
// Purpose: constants for the power-up self-test reporter
// Assumes: included by the design file by its bare name
// Notes:   codes, states, register offsets and field positions
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH

// service display codes
`define PST_CODE_PASS 4'h0
`define PST_CODE_ROM_LO 4'h1
`define PST_CODE_ROM_HI 4'h2
`define PST_CODE_ROM_BOTH 4'h3
`define PST_CODE_SRAM 4'h4
`define PST_CODE_IRAM 4'h5
`define PST_CODE_BIC 4'h6
`define PST_CODE_PIA 4'h7
`define PST_CODE_BUSY 4'hf

// sequencer states
`define PST_ST_BOOT 4'h0
`define PST_ST_IRAM 4'h1
`define PST_ST_SRAM 4'h2
`define PST_ST_ROM 4'h3
`define PST_ST_BIC 4'h4
`define PST_ST_PIA 4'h5
`define PST_ST_KERN 4'h6
`define PST_ST_INIT 4'h7
`define PST_ST_PASS 4'h8
`define PST_ST_HALT 4'h9
`define PST_ST_ROMLOOP 4'ha
`define PST_ST_SA 4'hb

// check selector driven to the checker logic
`define PST_SEL_IRAM 3'h1
`define PST_SEL_SRAM 3'h2
`define PST_SEL_ROM 3'h3
`define PST_SEL_BIC 3'h4
`define PST_SEL_PIA 3'h5
`define PST_SEL_KERN 3'h6
`define PST_SEL_NONE 3'h0

// boot settle count: last boot count, one beyond the two-stage synchroniser depth, before the strap is caught
`define PST_BOOT_CYCLES 2'h3

// apb register byte offsets
`define PST_OFS_CTRL 12'h000
`define PST_OFS_STATUS 12'h004

// control register fields
`define PST_CTRL_FORCE 0
`define PST_CTRL_RESTART 1

// status register fields
`define PST_STAT_CODE_LSB 0
`define PST_STAT_STATE_LSB 4
`define PST_STAT_HALTED 8
`define PST_STAT_PASSED 9
`define PST_STAT_SA 10
`define PST_STAT_FORCE 11

`endif

// >>> pst_self_test.v
// Purpose: power-up self-test sequencer and service status reporter
// Assumes: check results come from logic on core_clk_i; the analysis
//          jumper and the processor reset line are pins
// Notes:   apb slave with zero wait states; one clock domain
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "pst_defines.vh"

module pst_self_test #(
  parameter PAT_W = 16
) (
  input wire core_clk_i,
  input wire rst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // pins
  input wire analysis_mode_jumper_i,
  input wire proc_reset_i,
  // check handshake with same-clock checker logic
  output reg chk_req_o,
  output reg [2:0] chk_sel_o,
  input wire chk_done_i,
  input wire chk_pass_i,
  input wire rom_lower_section_fail_i,
  input wire rom_upper_section_fail_i,
  // status outputs
  output reg [3:0] service_digit_display_o,
  output reg dp_left_o,
  output reg dp_right_o,
  output reg fault_indicator_led_o,
  output reg addressed_indicator_led_o,
  output reg bic_init_o,
  output reg srq_o,
  output reg halt_n_o,
  output reg nmi_n_o,
  output reg bus_avail_o,
  output reg rom_loop_upper_o,
  output reg rom_loop_rd_o,
  output reg phi2_ref_o,
  output reg start_stop_test_point_o,
  output reg [PAT_W-1:0] analysis_pattern_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  reg jmp_s1_reg;
  reg jmp_s2_reg;
  reg rst_s1_reg;
  reg rst_s2_reg;
  reg [1:0] boot_cnt_reg;
  reg sa_mode_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] code_reg;
  reg [3:0] code_next;
  reg force_reg;
  reg restart_reg;
  reg phase_reg;
  reg [PAT_W-1:0] pat_reg;
  wire in_check;
  wire halted;
  wire wr_en;
  wire setup;
  reg [31:0] rdata;
  reg rd_err;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      jmp_s1_reg <= 1'b0;
      jmp_s2_reg <= 1'b0;
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      jmp_s1_reg <= analysis_mode_jumper_i;
      jmp_s2_reg <= jmp_s1_reg;
      rst_s1_reg <= proc_reset_i;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, answer in the access cycle
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;

  // read mux, unmapped offsets answer zero with an error
  always @* begin
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_i)
      `PST_OFS_CTRL: begin
        rdata[`PST_CTRL_FORCE] = force_reg;
      end
      `PST_OFS_STATUS: begin
        rdata[`PST_STAT_CODE_LSB +: 4] = code_reg;
        rdata[`PST_STAT_STATE_LSB +: 4] = state_reg;
        rdata[`PST_STAT_HALTED] = halted;
        rdata[`PST_STAT_PASSED] = (state_reg == `PST_ST_PASS);
        rdata[`PST_STAT_SA] = sa_mode_reg;
        rdata[`PST_STAT_FORCE] = force_reg;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // bus answer registers; restart is a one-cycle self-clearing strobe
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      force_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & rd_err;
      prdata_o <= (setup & ~pwrite_i) ? rdata : 32'h0000_0000;
      restart_reg <= 1'b0;
      if (wr_en && paddr_i == `PST_OFS_CTRL) begin
        force_reg <= pwdata_i[`PST_CTRL_FORCE];
        restart_reg <= pwdata_i[`PST_CTRL_RESTART];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture: caught once the synchroniser has settled after reset
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt_reg <= 2'h0;
      sa_mode_reg <= 1'b0;
    end else if (state_reg == `PST_ST_BOOT) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_cnt_reg == `PST_BOOT_CYCLES)
        sa_mode_reg <= jmp_s2_reg;
    end else begin
      boot_cnt_reg <= 2'h0;
    end
  end

  assign in_check = (state_reg >= `PST_ST_IRAM) &&
                    (state_reg <= `PST_ST_KERN);
  assign halted = (state_reg == `PST_ST_HALT) ||
                  (state_reg == `PST_ST_ROMLOOP);

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state and display code
  always @* begin
    state_next = state_reg;
    code_next = code_reg;
    case (state_reg)
      `PST_ST_BOOT: begin
        code_next = `PST_CODE_BUSY;
        if (boot_cnt_reg == `PST_BOOT_CYCLES)
          state_next = jmp_s2_reg ? `PST_ST_SA : `PST_ST_IRAM;
      end
      `PST_ST_IRAM: begin
        if (chk_done_i && chk_pass_i)
          state_next = `PST_ST_SRAM;
        else if (chk_done_i) begin
          code_next = `PST_CODE_IRAM;
          state_next = `PST_ST_HALT;
        end
      end
      `PST_ST_SRAM: begin
        if (chk_done_i && chk_pass_i)
          state_next = `PST_ST_ROM;
        else if (chk_done_i) begin
          code_next = `PST_CODE_SRAM;
          state_next = `PST_ST_HALT;
        end
      end
      `PST_ST_ROM: begin
        if (chk_done_i) begin
          // each section reports on its own
          case ({rom_upper_section_fail_i, rom_lower_section_fail_i})
            2'b01: code_next = `PST_CODE_ROM_LO;
            2'b10: code_next = `PST_CODE_ROM_HI;
            2'b11: code_next = `PST_CODE_ROM_BOTH;
            default: code_next = code_reg;
          endcase
          if (rom_upper_section_fail_i | rom_lower_section_fail_i)
            state_next = `PST_ST_ROMLOOP;
          else
            state_next = `PST_ST_BIC;
        end
      end
      `PST_ST_BIC: begin
        if (chk_done_i && chk_pass_i)
          state_next = `PST_ST_PIA;
        else if (chk_done_i) begin
          code_next = `PST_CODE_BIC;
          state_next = `PST_ST_HALT;
        end
      end
      `PST_ST_PIA: begin
        if (chk_done_i && chk_pass_i)
          state_next = `PST_ST_KERN;
        else if (chk_done_i) begin
          code_next = `PST_CODE_PIA;
          state_next = `PST_ST_HALT;
        end
      end
      `PST_ST_KERN: begin
        // kernel fault has no code of its own, F stays up
        if (chk_done_i)
          state_next = chk_pass_i ? `PST_ST_INIT : `PST_ST_HALT;
      end
      `PST_ST_INIT: begin
        code_next = `PST_CODE_PASS;
        state_next = `PST_ST_PASS;
      end
      `PST_ST_PASS: begin
        code_next = `PST_CODE_PASS;
      end
      `PST_ST_SA: begin
        code_next = `PST_CODE_PASS;
      end
      default: begin
        // halt states keep the code frozen
        code_next = code_reg;
      end
    endcase
    // restart from software reruns the whole routine except in sa mode
    if (restart_reg && state_reg != `PST_ST_SA) begin
      state_next = `PST_ST_IRAM;
      code_next = `PST_CODE_BUSY;
    end
  end

  // sequencer registers and check request
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= `PST_ST_BOOT;
      code_reg <= `PST_CODE_BUSY;
      chk_req_o <= 1'b0;
      chk_sel_o <= `PST_SEL_NONE;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      // request drops for one cycle between stages
      chk_req_o <= in_check & ~chk_done_i & ~restart_reg;
      case (state_reg)
        `PST_ST_IRAM: chk_sel_o <= `PST_SEL_IRAM;
        `PST_ST_SRAM: chk_sel_o <= `PST_SEL_SRAM;
        `PST_ST_ROM: chk_sel_o <= `PST_SEL_ROM;
        `PST_ST_BIC: chk_sel_o <= `PST_SEL_BIC;
        `PST_ST_PIA: chk_sel_o <= `PST_SEL_PIA;
        `PST_ST_KERN: chk_sel_o <= `PST_SEL_KERN;
        default: chk_sel_o <= `PST_SEL_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phi2 reference: core clock halved so its duty is exactly half
  // analysis pattern steps every second cycle in sa mode only; the gate flop toggles on each wrap
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
      pat_reg <= {PAT_W{1'b0}};
      start_stop_test_point_o <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (sa_mode_reg && phase_reg) begin
        pat_reg <= pat_reg + 1'b1;
        if (&pat_reg)
          start_stop_test_point_o <= ~start_stop_test_point_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicator and pin outputs, all registered
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      service_digit_display_o <= `PST_CODE_BUSY;
      dp_left_o <= 1'b0;
      dp_right_o <= 1'b0;
      fault_indicator_led_o <= 1'b0;
      addressed_indicator_led_o <= 1'b0;
      bic_init_o <= 1'b0;
      srq_o <= 1'b0;
      halt_n_o <= 1'b1;
      nmi_n_o <= 1'b1;
      bus_avail_o <= 1'b0;
      rom_loop_upper_o <= 1'b0;
      rom_loop_rd_o <= 1'b0;
      phi2_ref_o <= 1'b0;
      analysis_pattern_o <= {PAT_W{1'b0}};
    end else begin
      // forced mode overrides the shown digit only
      service_digit_display_o <= force_reg ? `PST_CODE_BUSY :
                                 code_reg;
      phi2_ref_o <= phase_reg;
      analysis_pattern_o <= pat_reg;
      // points track the clock phases so brightness shows duty
      dp_left_o <= (state_reg == `PST_ST_PASS) & phase_reg;
      dp_right_o <= rst_s2_reg |
                    ((state_reg == `PST_ST_PASS) & ~phase_reg) |
                    sa_mode_reg;
      // fault leds fully lit on halt, half duty in analysis mode
      fault_indicator_led_o <= halted | (sa_mode_reg & phase_reg);
      addressed_indicator_led_o <= halted | (sa_mode_reg & phase_reg);
      bic_init_o <= (state_reg == `PST_ST_INIT);
      srq_o <= (state_reg == `PST_ST_INIT) |
               (state_reg == `PST_ST_PASS);
      halt_n_o <= ~halted | sa_mode_reg;
      nmi_n_o <= 1'b1;
      bus_avail_o <= 1'b0;
      // alternate section reads for a probe to trigger on
      rom_loop_rd_o <= (state_reg == `PST_ST_ROMLOOP);
      if (state_reg == `PST_ST_ROMLOOP)
        rom_loop_upper_o <= ~rom_loop_upper_o;
      else
        rom_loop_upper_o <= 1'b0;
    end
  end

endmodule // pst_self_test

// >>> pst_self_test_sva.sv
// Purpose: port assertions for the self-test sequencer and reporter
// Assumes: bound to pst_self_test from the bench top file
// Notes:   leds blink in analysis mode, so led checks key off halt_n_o
`timescale 1ns/10ps
module pst_self_test_sva (
  input wire core_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire proc_reset_i,
  input wire chk_req_o,
  input wire [2:0] chk_sel_o,
  input wire chk_done_i,
  input wire [3:0] service_digit_display_o,
  input wire dp_right_o,
  input wire fault_indicator_led_o,
  input wire addressed_indicator_led_o,
  input wire srq_o,
  input wire halt_n_o,
  input wire nmi_n_o,
  input wire bus_avail_o,
  input wire rom_loop_upper_o,
  input wire rom_loop_rd_o,
  input wire phi2_ref_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // check handshake: a pending request stands until the answer
  sequence req_wait; chk_req_o && !chk_done_i; endsequence
  sequence req_hit; chk_req_o && chk_done_i; endsequence
  hold_sel_a: assert property (req_wait |=> chk_req_o && $stable(chk_sel_o))
    else $error("check request changed before its answer");
  drop_req_a: assert property (req_hit |=> !chk_req_o)
    else $error("check request still high after answer");
  // halted states keep both indicators lit
  halt_leds_a: assert property (!halt_n_o [*2] |-> fault_indicator_led_o && addressed_indicator_led_o)
    else $error("indicators dark while halted");
  rom_loop_a: assert property (rom_loop_rd_o && $past(rom_loop_rd_o) |-> rom_loop_upper_o != $past(rom_loop_upper_o))
    else $error("rom loop not alternating sections");
  // pass state: request only with digit 0 after it settles
  pass_code_a: assert property (srq_o [*4] |-> service_digit_display_o == 4'h0 && halt_n_o)
    else $error("service request without passing digit");
  // sync depth plus output flop fits inside five cycles
  dp_reset_a: assert property (proc_reset_i [*5] |-> dp_right_o)
    else $error("right point dark while reset line high");
  quiet_lines_a: assert property (nmi_n_o && !bus_avail_o)
    else $error("held lines not at their constant level");
  // output flop lags the divider, so the first toggle is seen two edges in
  phi2_div_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    phi2_ref_o != $past(phi2_ref_o))
    else $error("analyzer clock reference not toggling");
  apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access cycle");
  apb_err_a: assert property (pslverr_o |-> pready_o)
    else $error("error response without ready");
endmodule // pst_self_test_sva

// >>> pst_sig_analyzer.sv
// Purpose: model of the external signature analyzer on the test points
// Assumes: start and stop share one lead, clocked by the phi2 reference
// Notes:   counts gate changes only; drives nothing back into the block
`timescale 1ns/10ps
module pst_sig_analyzer (
  input wire phi2_i,
  input wire gate_i,
  output reg [15:0] gate_edges_o
);
  reg gate_last;
  initial begin
    gate_edges_o = 16'h0000;
    gate_last = 1'b0;
  end
  // falling edges only, hold and self test off, one lead for start/stop
  always @(negedge phi2_i) begin
    if (gate_i !== gate_last) gate_edges_o <= gate_edges_o + 16'h0001;
    gate_last <= gate_i;
  end
endmodule // pst_sig_analyzer

// >>> power_up_self_test_reporter_tb_top.sv
// Purpose: self-checking bench for the self-test sequencer and reporter
// Assumes: bench plays the same-clock checker logic and the apb master
// Notes:   PAT_W shrunk to 4 so the analysis gate wraps quickly
`timescale 1ns/10ps
`include "pst_defines.vh"
module power_up_self_test_reporter_tb_top;
  reg core_clk_i, rst_i, psel_i, penable_i, pwrite_i, analysis_mode_jumper_i;
  reg [11:0] paddr_i;
  reg [31:0] pwdata_i, rd;
  reg proc_reset_i, chk_done_i, chk_pass_i, err, sa, sb;
  reg rom_lower_section_fail_i, rom_upper_section_fail_i;
  wire [31:0] prdata_o;
  wire [3:0] service_digit_display_o, analysis_pattern_o;
  wire [2:0] chk_sel_o;
  wire [15:0] gate_edges;
  wire pready_o, pslverr_o, chk_req_o, dp_left_o, dp_right_o, srq_o;
  wire fault_indicator_led_o, addressed_indicator_led_o, bic_init_o;
  wire halt_n_o, nmi_n_o, bus_avail_o, rom_loop_upper_o, rom_loop_rd_o;
  wire phi2_ref_o, start_stop_test_point_o;
  integer num_errors = 0, samples_checked = 0, bic_cnt = 0, i, k, g0;
  reg [3:0] exp_q [$];
  integer fst [7] = '{1, 2, 3, 3, 3, 4, 5};
  reg [3:0] cod [7] = '{4'h5, 4'h4, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
  reg [6:0] lom = 7'h14, him = 7'h18;
  reg [11:0] ua;
  reg [3:0] p0;
  pst_self_test #(.PAT_W(4)) i_dut (.core_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .analysis_mode_jumper_i, .proc_reset_i, .chk_req_o,
    .chk_sel_o, .chk_done_i, .chk_pass_i, .rom_lower_section_fail_i,
    .rom_upper_section_fail_i, .service_digit_display_o, .dp_left_o,
    .dp_right_o, .fault_indicator_led_o, .addressed_indicator_led_o,
    .bic_init_o, .srq_o, .halt_n_o, .nmi_n_o, .bus_avail_o,
    .rom_loop_upper_o, .rom_loop_rd_o, .phi2_ref_o,
    .start_stop_test_point_o, .analysis_pattern_o);
  pst_sig_analyzer i_sa (.phi2_i(phi2_ref_o),
    .gate_i(start_stop_test_point_o), .gate_edges_o(gate_edges));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task summarize;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tmo;
    num_errors = num_errors + 1;
    summarize;
  endtask
  task chk(input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task chk_code(input [3:0] e, input [3:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("unexpected code at %0t exp %h got %h", $time, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n = n + 1;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) tmo;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rst_run(input j);
    rst_i <= 1'b1;
    analysis_mode_jumper_i <= j;
    {chk_done_i, rom_lower_section_fail_i, rom_upper_section_fail_i} <= 3'h0;
    repeat (6) @(posedge core_clk_i);
    chk_code(4'hf, service_digit_display_o);
    chk(1, halt_n_o);
    rst_i <= 1'b0;
  endtask
  // acts as checker logic; stops after the failing stage fs (0: none)
  task run(input integer fs, input lo, input hi);
    integer s, n;
    for (s = 1; s <= ((fs == 0) ? 6 : fs); s = s + 1) begin
      n = 0;
      do begin
        @(posedge core_clk_i);
        n = n + 1;
      end while (chk_req_o !== 1'b1 && n < 50);
      if (chk_req_o !== 1'b1) tmo;
      chk(s, chk_sel_o);
      repeat ($urandom % 3) @(posedge core_clk_i);
      chk_done_i <= 1'b1;
      chk_pass_i <= (s != fs);
      rom_lower_section_fail_i <= lo && s == 3;
      rom_upper_section_fail_i <= hi && s == 3;
      @(posedge core_clk_i);
      chk_done_i <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // results appear as a change of the shown digit away from F
  always @(service_digit_display_o) begin
    if (rst_i === 1'b0 && service_digit_display_o !== 4'hf) begin
      if (exp_q.size() == 0) chk_code(4'hf, service_digit_display_o);
      else chk_code(exp_q.pop_front(), service_digit_display_o);
    end
  end
  always @(posedge core_clk_i) if (bic_init_o === 1'b1) bic_cnt <= bic_cnt + 1;
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, proc_reset_i} = 5'h10;
    {chk_done_i, chk_pass_i, analysis_mode_jumper_i} = 3'h0;
    {rom_lower_section_fail_i, rom_upper_section_fail_i} = 2'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    void'($urandom(5347));
    // every stage passes
    rst_run(0);
    exp_q.push_back(4'h0);
    run(0, 0, 0);
    repeat (4) @(posedge core_clk_i);
    chk(1, srq_o);
    chk(1, bic_cnt);
    {sa, sb} = 2'b00;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge core_clk_i);
      sa = sa | dp_left_o;
      sb = sb | dp_right_o;
    end
    chk(1, sa & sb);
    // each halting fault with a code of its own in turn
    for (k = 0; k < 7; k = k + 1) begin
      rst_run(0);
      exp_q.push_back(cod[k]);
      run(fst[k], lom[k], him[k]);
      repeat (3) @(posedge core_clk_i);
      chk(0, halt_n_o);
      chk(1, fault_indicator_led_o & addressed_indicator_led_o);
      chk(fst[k] == 3, rom_loop_rd_o);
      chk(0, srq_o);
    end
    // late answer after the halt must not move the frozen code
    chk_done_i <= 1'b1;
    @(posedge core_clk_i);
    chk_done_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk_code(4'h7, service_digit_display_o);
    apb(1, `PST_OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge core_clk_i);
    chk_code(4'hf, service_digit_display_o);
    apb(0, `PST_OFS_STATUS, 32'h0000_0000);
    chk(1, rd[`PST_STAT_FORCE] & rd[`PST_STAT_HALTED]);
    exp_q.push_back(4'h7);
    apb(1, `PST_OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge core_clk_i);
    // random unmapped word: write ignored, read refused with zero
    // address kept in a bench variable: the bus pins are the task's to drive
    ua = 12'h008 + 12'((($urandom % 1022)) << 2);
    apb(1, ua, $urandom);
    apb(0, ua, 32'h0000_0000);
    chk(1, err);
    chk(0, rd);
    // software restart reruns the whole routine through to a pass
    apb(1, `PST_OFS_CTRL, 32'h0000_0002);
    exp_q.push_back(4'h0);
    run(0, 0, 0);
    repeat (4) @(posedge core_clk_i);
    chk(1, srq_o);
    proc_reset_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk(1, dp_right_o);
    proc_reset_i <= 1'b0;
    // analysis strap fitted at power-up
    rst_run(1);
    exp_q.push_back(4'h0);
    g0 = gate_edges;
    repeat (100) @(posedge core_clk_i);
    chk(1, dp_right_o);
    p0 = analysis_pattern_o;
    {sa, sb} = 2'b00;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge core_clk_i);
      sa = sa | fault_indicator_led_o;
      sb = sb | ~addressed_indicator_led_o;
    end
    chk(1, sa & sb);
    // eight core edges are four phi2 periods, one pattern step each
    p0 = p0 + 4'h4;
    chk(p0, analysis_pattern_o);
    chk(1, gate_edges != g0);
    chk(1, halt_n_o & nmi_n_o & ~bus_avail_o);
    chk(0, exp_q.size());
    summarize;
  end
endmodule // power_up_self_test_reporter_tb_top
bind pst_self_test pst_self_test_sva i_sva (.core_clk_i, .rst_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .proc_reset_i, .chk_req_o, .chk_sel_o,
  .chk_done_i, .service_digit_display_o, .dp_right_o, .fault_indicator_led_o,
  .addressed_indicator_led_o, .srq_o, .halt_n_o, .nmi_n_o, .bus_avail_o,
  .rom_loop_upper_o, .rom_loop_rd_o, .phi2_ref_o);
